// ### logic/sfc_defines.vh
// shared constants for the serial flash slave control block
// assumes includers take the opcode values as a local choice of this design
//
// Functional notes
// - serial output changes after each falling clock edge
// - instruction, address and data bits captured on rising clock edges
// - chip select high floats the serial output
// - deselected device stays active until internal cycle ends, then standby
// - nothing decoded before first chip select falling edge after reset
// - hold floats output, ignores clock and input, keeps sequence position
// - hold only takes effect while chip select is low
// - clock idle level 0 or 1 both work; rise samples, fall shifts
// - page program takes 1 to 256 bytes within one page
// - page program needs a prior write unlock
// - program only clears bits; erase sets bytes to ff
// - sector wipe clears a sector, bulk wipe clears the whole array
// - erase needs a prior write unlock
// - busy flag set for whole status write, program or erase cycle
// - status shows the write unlock latch
// - deep sleep entered by its command, left by wake command
// - in deep sleep every command except wake is ignored
// - three protect bits size the region immune to program and erase
// - lock bit plus low write protect freezes lock and protect bits
// - array is 16 sectors of 256 pages of 256 bytes
// - all fields travel most significant bit first
// - unlock latch cleared at reset and after lock, write or erase completion
// - program, erase, status write need a bit count multiple of eight
// - bulk wipe only when all protect bits are zero
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// command codes
`define SFC_OP_UNLOCK 8'h21
`define SFC_OP_LOCK 8'h22
`define SFC_OP_RDSTAT 8'h23
`define SFC_OP_WRSTAT 8'h24
`define SFC_OP_READ 8'h25
`define SFC_OP_PROG 8'h26
`define SFC_OP_SECT 8'h27
`define SFC_OP_BULK 8'h28
`define SFC_OP_SLEEP 8'h29
`define SFC_OP_WAKE 8'h2a

// status byte fields
`define SFC_ST_BUSY 0
`define SFC_ST_WEL 1
`define SFC_ST_BP_LO 2
`define SFC_ST_BP_HI 4
`define SFC_ST_LOCK 7

// synchroniser bit positions and idle reset value
`define SFC_I_SCK 0
`define SFC_I_CS 1
`define SFC_I_MOSI 2
`define SFC_I_HOLD 3
`define SFC_I_WP 4
`define SFC_SYNC_RST 5'h1a
// edges after reset before the synchronised select is trusted
`define SFC_WARM_DONE 2'h3

// array geometry and operations
`define SFC_SECTORS 5'h10
`define SFC_LAST_IDX 8'hff
`define SFC_ERASED 8'hff
`define SFC_AOP_PROG 2'h0
`define SFC_AOP_SECT 2'h1
`define SFC_AOP_BULK 2'h2

// byte counts of command frames
`define SFC_BC_ADDR 3'h3
`define SFC_BC_DATA 3'h4
`define SFC_BC_MAX 3'h5

`endif

// ### logic/sfc_buf2.v
// two-entry valid/ready buffer
// assumes both sides on clk; full when two words held
`timescale 1ns/100ps
module sfc_buf2 #(
	parameter W = 30
) (
	input wire clk,
	input wire rst_n,
	input wire inValid,
	output wire inReady,
	input wire [W-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [W-1:0] outData
);
	reg [W-1:0] head_reg;
	reg [W-1:0] tail_reg;
	reg [1:0] count_reg;
	wire push;
	wire pop;

	assign inReady = (count_reg != 2'h2);
	assign outValid = (count_reg != 2'h0);
	assign outData = head_reg;
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// storage and occupancy
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			head_reg <= {W{1'b0}};
			tail_reg <= {W{1'b0}};
			count_reg <= 2'h0;
		end else begin
			if (pop) begin
				head_reg <= (count_reg == 2'h2) ? tail_reg : inData;
			end else if (push && count_reg == 2'h0) begin
				head_reg <= inData;
			end
			if (push && (count_reg == 2'h2 || (count_reg == 2'h1 && !pop))) begin
				tail_reg <= inData;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 2'h1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end
endmodule // sfc_buf2

// ### logic/sfc_core.v
// serial flash slave control: pin side sequencer, status byte, array ops
// assumes array read data valid within two clk cycles of arrRdAddr;
// the array applies program as bitwise and, erase as fill with ff
`timescale 1ns/100ps
`include "sfc_defines.vh"
module sfc_core #(
	parameter [7:0] SIG_VALUE = 8'h5a, // arbitrary signature value
	parameter [31:0] STAT_CYCLES = 32'd1000,
	parameter [31:0] PROG_CYCLES = 32'd2000,
	parameter [31:0] SECT_CYCLES = 32'd20000,
	parameter [31:0] BULK_CYCLES = 32'd80000
) (
	input wire clk,
	input wire rst_n,
	input wire sckPin,
	input wire csPin_n,
	input wire mosiPin,
	input wire holdPin_n,
	input wire wpPin_n,
	output reg misoOut,
	output wire misoOe,
	output reg [19:0] arrRdAddr,
	input wire [7:0] arrRdData,
	output wire arrValid,
	input wire arrReady,
	output wire [1:0] arrOp,
	output wire [19:0] arrAddr,
	output wire [7:0] arrData,
	output wire standbyMode,
	output wire deepSleep,
	output wire [7:0] statusByte
);
	reg [4:0] meta_reg;
	reg [4:0] sync_reg;
	reg sckPrev_reg;
	reg csPrev_reg;
	reg [1:0] warm_reg;
	reg hold_reg;
	reg armed_reg;
	reg ignore_reg;
	reg [2:0] bitIdx_reg;
	reg [2:0] byteCnt_reg;
	reg [6:0] sh_reg;
	reg [7:0] opcode_reg;
	reg [23:0] addr_reg;
	reg [7:0] stData_reg;
	reg [255:0] mask_reg;
	reg [7:0] page [0:255];
	reg wel_reg;
	reg lock_reg;
	reg [2:0] bp_reg;
	reg sleep_reg;
	reg [31:0] timer_reg;
	reg streaming_reg;
	reg [7:0] streamIdx_reg;
	reg [11:0] pageBase_reg;
	reg erasePend_reg;
	reg [1:0] eraseOp_reg;
	reg [19:0] eraseAddr_reg;
	reg busyPrev_reg;
	reg [6:0] tx_reg;
	reg outEn_reg;
	reg [4:0] protN;
	wire sckS;
	wire csS;
	wire mosiS;
	wire holdS;
	wire wpS;
	wire sckRise;
	wire sckFall;
	wire csFall;
	wire csRise;
	wire live;
	wire byteDone;
	wire [7:0] nb;
	wire busy;
	wire ex;
	wire hwProt;
	wire pageProt;
	wire bufInValid;
	wire bufInReady;
	wire [29:0] bufInData;
	wire [29:0] bufOutData;
	wire outPhase;
	wire [7:0] nxt;
	wire cycEnd;

	// two flops on every pin input
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= `SFC_SYNC_RST;
			sync_reg <= `SFC_SYNC_RST;
			sckPrev_reg <= 1'b0;
			csPrev_reg <= 1'b1;
			warm_reg <= 2'h0;
		end else begin
			meta_reg <= {wpPin_n, holdPin_n, mosiPin, csPin_n, sckPin};
			sync_reg <= meta_reg;
			sckPrev_reg <= sync_reg[`SFC_I_SCK];
			csPrev_reg <= sync_reg[`SFC_I_CS];
			if (warm_reg != `SFC_WARM_DONE) begin
				warm_reg <= warm_reg + 2'h1;
			end
		end
	end

	assign sckS = sync_reg[`SFC_I_SCK];
	assign csS = sync_reg[`SFC_I_CS];
	assign mosiS = sync_reg[`SFC_I_MOSI];
	assign holdS = sync_reg[`SFC_I_HOLD];
	assign wpS = sync_reg[`SFC_I_WP];
	// edges found the same way in either idle level
	assign sckRise = sckS & ~sckPrev_reg;
	assign sckFall = ~sckS & sckPrev_reg;
	// select held low through reset is no falling edge
	assign csFall = ~csS & csPrev_reg & (warm_reg == `SFC_WARM_DONE);
	assign csRise = csS & ~csPrev_reg;
	// clock and input dead while paused
	assign live = ~csS & ~hold_reg & armed_reg & ~ignore_reg;
	// a bit lands on each rising edge
	assign byteDone = live & sckRise & (bitIdx_reg == 3'h7);
	// newest bit enters at the bottom
	assign nb = {sh_reg, mosiS};

	// pause state only follows hold while selected
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= 1'b0;
		end else if (csS) begin
			hold_reg <= 1'b0;
		end else if (!sckS) begin
			hold_reg <= ~holdS; // starts and ends only with clock low
		end
	end

	// instruction framing and capture
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
			ignore_reg <= 1'b0;
			bitIdx_reg <= 3'h0;
			byteCnt_reg <= 3'h0;
			sh_reg <= 7'h00;
			opcode_reg <= 8'h00;
			addr_reg <= 24'h000000;
			stData_reg <= 8'h00;
			mask_reg <= 256'h0;
		end else if (csFall) begin
			armed_reg <= 1'b1;
			ignore_reg <= 1'b0;
			bitIdx_reg <= 3'h0;
			byteCnt_reg <= 3'h0;
			opcode_reg <= 8'h00;
			if (!streaming_reg) begin
				mask_reg <= 256'h0;
			end
		end else if (live && sckRise) begin
			sh_reg <= nb[6:0];
			bitIdx_reg <= bitIdx_reg + 3'h1;
			if (bitIdx_reg == 3'h7) begin
				if (byteCnt_reg != `SFC_BC_MAX) begin
					byteCnt_reg <= byteCnt_reg + 3'h1;
				end
				if (byteCnt_reg == 3'h0) begin
					opcode_reg <= nb;
					// asleep, only the wake command is heard
					if (sleep_reg && nb != `SFC_OP_WAKE) begin
						ignore_reg <= 1'b1;
					end
				end else if (byteCnt_reg <= `SFC_BC_ADDR) begin
					addr_reg <= {addr_reg[15:0], nb};
				end else if (opcode_reg == `SFC_OP_PROG && !busy) begin
					mask_reg[addr_reg[7:0]] <= 1'b1;
					addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
				end
				if (byteCnt_reg == 3'h1) begin
					stData_reg <= nb;
				end
			end
		end
	end

	// page data holding, written while idle only
	always @(posedge clk) begin
		if (byteDone && byteCnt_reg >= `SFC_BC_DATA && opcode_reg == `SFC_OP_PROG && !busy) begin
			page[addr_reg[7:0]] <= nb;
		end
	end

	// protected sector count from the three bits
	always @* begin
		case (bp_reg)
			3'h0: protN = 5'h00;
			3'h1: protN = 5'h01;
			3'h2: protN = 5'h02;
			3'h3: protN = 5'h04;
			3'h4: protN = 5'h08;
			default: protN = `SFC_SECTORS;
		endcase
	end

	// sector index is the top four address bits
	assign pageProt = ({1'b0, addr_reg[19:16]} >= (`SFC_SECTORS - protN));
	// lock bit with low protect pin
	assign hwProt = lock_reg & ~wpS;
	// busy covers timer, streaming and queued array work
	assign busy = (timer_reg != 32'h0) | streaming_reg | erasePend_reg | arrValid;
	assign cycEnd = busyPrev_reg & ~busy;
	assign ex = csRise & armed_reg & ~ignore_reg & (bitIdx_reg == 3'h0);

	// execution at deselect and internal cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wel_reg <= 1'b0;
			lock_reg <= 1'b0;
			bp_reg <= 3'h0;
			sleep_reg <= 1'b0;
			timer_reg <= 32'h0;
			streaming_reg <= 1'b0;
			streamIdx_reg <= 8'h00;
			pageBase_reg <= 12'h000;
			erasePend_reg <= 1'b0;
			eraseOp_reg <= `SFC_AOP_SECT;
			eraseAddr_reg <= 20'h00000;
			busyPrev_reg <= 1'b0;
		end else begin
			busyPrev_reg <= busy;
			if (timer_reg != 32'h0) begin
				timer_reg <= timer_reg - 32'h1;
			end
			// latch drops when a cycle completes
			if (cycEnd) begin
				wel_reg <= 1'b0;
			end
			// program words feed out of the page, one per set mask bit
			if (streaming_reg && (!mask_reg[streamIdx_reg] || bufInReady)) begin
				streamIdx_reg <= streamIdx_reg + 8'h01;
				if (streamIdx_reg == `SFC_LAST_IDX) begin
					streaming_reg <= 1'b0;
				end
			end
			if (erasePend_reg && !streaming_reg && bufInReady) begin
				erasePend_reg <= 1'b0;
			end
			// wake acts as soon as its opcode is in
			if (byteDone && byteCnt_reg == 3'h0 && nb == `SFC_OP_WAKE) begin
				sleep_reg <= 1'b0;
			end
			// write type commands refused while busy
			if (ex && !busy) begin
				case (opcode_reg)
					`SFC_OP_UNLOCK: begin
						if (byteCnt_reg == 3'h1) begin
							wel_reg <= 1'b1;
						end
					end
					`SFC_OP_LOCK: begin
						if (byteCnt_reg == 3'h1) begin
							wel_reg <= 1'b0;
						end
					end
					`SFC_OP_WRSTAT: begin
						if (byteCnt_reg == 3'h2 && wel_reg && !hwProt) begin
							lock_reg <= stData_reg[`SFC_ST_LOCK];
							bp_reg <= stData_reg[`SFC_ST_BP_HI:`SFC_ST_BP_LO];
							timer_reg <= STAT_CYCLES;
						end
					end
					`SFC_OP_PROG: begin
						// needs latch; at least one data byte
						if (byteCnt_reg == `SFC_BC_MAX && wel_reg && !pageProt) begin
							streaming_reg <= 1'b1;
							streamIdx_reg <= 8'h00;
							pageBase_reg <= addr_reg[19:8];
							timer_reg <= PROG_CYCLES;
						end
					end
					`SFC_OP_SECT: begin
						if (byteCnt_reg == `SFC_BC_DATA && wel_reg && !pageProt) begin
							erasePend_reg <= 1'b1;
							eraseOp_reg <= `SFC_AOP_SECT;
							eraseAddr_reg <= {addr_reg[19:16], 16'h0000};
							timer_reg <= SECT_CYCLES;
						end
					end
					`SFC_OP_BULK: begin
						// bulk wipe only with no protection
						if (byteCnt_reg == 3'h1 && wel_reg && bp_reg == 3'h0) begin
							erasePend_reg <= 1'b1;
							eraseOp_reg <= `SFC_AOP_BULK;
							eraseAddr_reg <= 20'h00000;
							timer_reg <= BULK_CYCLES;
						end
					end
					`SFC_OP_SLEEP: begin
						if (byteCnt_reg == 3'h1) begin
							sleep_reg <= 1'b1;
						end
					end
					default: begin
						sleep_reg <= sleep_reg;
					end
				endcase
			end
		end
	end

	// array work queue input
	assign bufInValid = streaming_reg ? mask_reg[streamIdx_reg] : erasePend_reg;
	assign bufInData = streaming_reg ?
		{`SFC_AOP_PROG, pageBase_reg, streamIdx_reg, page[streamIdx_reg]} :
		{eraseOp_reg, eraseAddr_reg, `SFC_ERASED};

	sfc_buf2 #(
		.W(30)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData(bufInData),
		.outValid(arrValid),
		.outReady(arrReady),
		.outData(bufOutData)
	);

	assign arrOp = bufOutData[29:28];
	assign arrAddr = bufOutData[27:8];
	assign arrData = bufOutData[7:0];

	// data out phases and the byte to send
	assign outPhase = (opcode_reg == `SFC_OP_RDSTAT && byteCnt_reg != 3'h0) ||
		(opcode_reg == `SFC_OP_READ && byteCnt_reg >= `SFC_BC_DATA) ||
		(opcode_reg == `SFC_OP_WAKE && byteCnt_reg >= `SFC_BC_DATA);
	assign nxt = (opcode_reg == `SFC_OP_RDSTAT) ? statusByte :
		(opcode_reg == `SFC_OP_READ) ? arrRdData : SIG_VALUE;

	// serial output shifter
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			misoOut <= 1'b0;
			tx_reg <= 7'h00;
			outEn_reg <= 1'b0;
			arrRdAddr <= 20'h00000;
		end else if (csS) begin
			outEn_reg <= 1'b0;
			misoOut <= 1'b0;
		end else begin
			if (byteDone && byteCnt_reg == `SFC_BC_ADDR && opcode_reg == `SFC_OP_READ) begin
				arrRdAddr <= {addr_reg[11:0], nb};
			end
			// launch on falling edge, msb first
			if (live && sckFall && outPhase) begin
				if (bitIdx_reg == 3'h0) begin
					misoOut <= nxt[7];
					tx_reg <= nxt[6:0];
					outEn_reg <= 1'b1;
					if (opcode_reg == `SFC_OP_READ) begin
						arrRdAddr <= arrRdAddr + 20'h00001;
					end
				end else begin
					misoOut <= tx_reg[6];
					tx_reg <= {tx_reg[5:0], 1'b0};
				end
			end
		end
	end

	// float when deselected; float in hold
	assign misoOe = ~csS & ~hold_reg & outEn_reg;
	assign standbyMode = csS & ~busy & ~sleep_reg;
	assign deepSleep = sleep_reg;
	assign statusByte = {lock_reg, 2'b00, bp_reg, wel_reg & ~cycEnd, busy}; // latch drop shown with busy fall
endmodule // sfc_core

// ### tb/sfc_array_model.sv
// array partner: byte memory behind the op and read ports
// assumes one op per handshake; ready toggles to stall
`timescale 1ns/100ps
module sfc_array_model (
	input wire clk,
	input wire [19:0] arrRdAddr,
	output reg [7:0] arrRdData,
	input wire arrValid,
	output reg arrReady,
	input wire [1:0] arrOp,
	input wire [19:0] arrAddr,
	input wire [7:0] arrData
);
reg [7:0] mem [0:1048575];
integer i;
// erased array at start
initial begin
	arrReady = 1'b0;
	arrRdData = 8'hff;
	for (i = 0; i < 1048576; i = i + 1)
		mem[i] = 8'hff;
end
// read data one cycle after address
always @(posedge clk) begin
	arrRdData <= mem[arrRdAddr];
end
// ready on alternate cycles, ops applied on handshake
always @(posedge clk) begin
	arrReady <= ~arrReady;
	if (arrValid && arrReady) begin
		if (arrOp == 2'h0)
			mem[arrAddr] <= mem[arrAddr] & arrData;
		else
			for (i = 0; i < 1048576; i = i + 1)
				if (arrOp == 2'h2 || i[19:16] == arrAddr[19:16])
					mem[i] <= 8'hff;
	end
end
endmodule // sfc_array_model

// ### tb/sfc_monitor.sv
// checker on the flash control ports
// assumes single clk domain, async active low reset
`timescale 1ns/100ps
module sfc_monitor (
	input wire clk,
	input wire rst_n,
	input wire sckPin,
	input wire csPin_n,
	input wire mosiPin,
	input wire holdPin_n,
	input wire wpPin_n,
	input wire misoOut,
	input wire misoOe,
	input wire [19:0] arrRdAddr,
	input wire [7:0] arrRdData,
	input wire arrValid,
	input wire arrReady,
	input wire [1:0] arrOp,
	input wire [19:0] arrAddr,
	input wire [7:0] arrData,
	input wire standbyMode,
	input wire deepSleep,
	input wire [7:0] statusByte
);
wire [2:0] bp = statusByte[4:2];
// sectors left writable for the protect setting
wire [4:0] unprot = (bp == 3'h0) ? 5'h10 : (bp > 3'h4) ? 5'h00 : 5'h10 - (5'h01 << (bp - 3'h1));
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
property p_csFloat; csPin_n [*4] |-> !misoOe; endproperty
a_csFloat: assert property (p_csFloat) else $error("output driven while deselected");
property p_hold; (!holdPin_n && !csPin_n && !sckPin) [*6] |-> !misoOe; endproperty
a_hold: assert property (p_hold) else $error("output driven in hold");
property p_standby; standbyMode && $past(rst_n, 2) |-> !statusByte[0] && !deepSleep && $past(csPin_n, 2); endproperty
a_standby: assert property (p_standby) else $error("standby while busy");
property p_busyOps; arrValid |-> statusByte[0]; endproperty
a_busyOps: assert property (p_busyOps) else $error("array op without busy");
property p_welClr; $fell(statusByte[0]) |-> !statusByte[1]; endproperty
a_welClr: assert property (p_welClr) else $error("unlock kept after cycle");
property p_sleepQuiet; deepSleep |-> !arrValid; endproperty
a_sleepQuiet: assert property (p_sleepQuiet) else $error("array op in sleep");
property p_eraseData; arrValid && arrOp != 2'h0 |-> arrData == 8'hff && arrOp != 2'h3; endproperty
a_eraseData: assert property (p_eraseData) else $error("erase data not ff");
property p_sectBase; arrValid && arrOp == 2'h1 |-> arrAddr[15:0] == 16'h0000; endproperty
a_sectBase: assert property (p_sectBase) else $error("sector erase not at base");
property p_bulkProt; arrValid && arrOp == 2'h2 |-> bp == 3'h0; endproperty
a_bulkProt: assert property (p_bulkProt) else $error("bulk erase while protected");
property p_prot; arrValid && arrOp != 2'h2 |-> {1'b0, arrAddr[19:16]} < unprot; endproperty
a_prot: assert property (p_prot) else $error("op in protected sector");
property p_opStable; arrValid && !arrReady |=> arrValid && $stable(arrOp) && $stable(arrAddr) && $stable(arrData); endproperty
a_opStable: assert property (p_opStable) else $error("array op changed while stalled");
endmodule // sfc_monitor
bind sfc_core sfc_monitor i_mon (.clk(clk), .rst_n(rst_n), .sckPin(sckPin), .csPin_n(csPin_n),
	.mosiPin(mosiPin), .holdPin_n(holdPin_n), .wpPin_n(wpPin_n), .misoOut(misoOut), .misoOe(misoOe),
	.arrRdAddr(arrRdAddr), .arrRdData(arrRdData), .arrValid(arrValid), .arrReady(arrReady),
	.arrOp(arrOp), .arrAddr(arrAddr), .arrData(arrData), .standbyMode(standbyMode),
	.deepSleep(deepSleep), .statusByte(statusByte));

// ### tb/tb_top.sv
// bench: acts as serial bus master, checks status and array contents
// assumes 200 MHz clk, serial clock period ten clk cycles
`timescale 1ns/100ps
module tb_top;
reg clk = 1'b0, rst_n = 1'b0, sckPin = 1'b0, csPin_n = 1'b0, mosiPin = 1'b0, holdPin_n = 1'b1, wpPin_n = 1'b1;
reg cpol = 1'b0;
reg [7:0] s, d;
wire misoOut, misoOe, arrValid, arrReady, standbyMode, deepSleep;
wire [19:0] arrRdAddr, arrAddr;
wire [7:0] arrRdData, arrData, statusByte;
wire [1:0] arrOp;
integer nFail = 0, checkCount = 0, m;
initial begin
	forever #2.5 clk = ~clk;
end
sfc_core #(.STAT_CYCLES(200), .PROG_CYCLES(400), .SECT_CYCLES(600), .BULK_CYCLES(800)) i_dut (
	.clk(clk), .rst_n(rst_n), .sckPin(sckPin), .csPin_n(csPin_n), .mosiPin(mosiPin),
	.holdPin_n(holdPin_n), .wpPin_n(wpPin_n), .misoOut(misoOut), .misoOe(misoOe),
	.arrRdAddr(arrRdAddr), .arrRdData(arrRdData), .arrValid(arrValid), .arrReady(arrReady),
	.arrOp(arrOp), .arrAddr(arrAddr), .arrData(arrData), .standbyMode(standbyMode),
	.deepSleep(deepSleep), .statusByte(statusByte));
sfc_array_model i_arr (.clk(clk), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData), .arrValid(arrValid),
	.arrReady(arrReady), .arrOp(arrOp), .arrAddr(arrAddr), .arrData(arrData));
task tick(input integer n);
	repeat (n) @(posedge clk);
endtask
task chk(input [31:0] got, input [31:0] exp);
	begin
		checkCount = checkCount + 1;
		if (got !== exp) begin
			nFail = nFail + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
endtask
task finalReport;
	begin
		$display("checks=%0d errors=%0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
endtask
// one byte each way, msb first, sample on rise
task xfer(input [7:0] tx, output [7:0] rx);
	integer i;
	for (i = 7; i >= 0; i = i - 1) begin
		@(posedge clk);
		sckPin <= 1'b0;
		mosiPin <= tx[i];
		tick(5);
		sckPin <= 1'b1;
		rx[i] = misoOut;
		tick(4);
	end
endtask
task sel;
	begin
		@(posedge clk);
		csPin_n <= 1'b0;
		tick(4);
	end
endtask
task desel;
	begin
		@(posedge clk);
		sckPin <= cpol;
		tick(5);
		csPin_n <= 1'b1;
		tick(10);
	end
endtask
task op1(input [7:0] c);
	begin
		sel;
		xfer(c, d);
		desel;
	end
endtask
task op4(input [7:0] c, input [19:0] a);
	begin
		sel;
		xfer(c, d);
		xfer({4'h0, a[19:16]}, d);
		xfer(a[15:8], d);
		xfer(a[7:0], d);
	end
endtask
task rdstat;
	begin
		sel;
		xfer(8'h23, d);
		xfer(8'h00, s);
		chk(misoOe, 1);
		desel;
	end
endtask
task rdbyte(input [19:0] a, input [7:0] e);
	begin
		op4(8'h25, a);
		xfer(8'h00, d);
		desel;
		chk(d, e);
	end
endtask
// poll busy with a bound
task idle;
	integer k;
	begin
		k = 0;
		rdstat;
		while (s[0] === 1'b1 && k < 100) begin
			rdstat;
			k = k + 1;
		end
		if (s[0] !== 1'b0) begin
			nFail = nFail + 1;
			finalReport;
		end
	end
endtask
task wrstat(input [7:0] v);
	begin
		op1(8'h21);
		sel;
		xfer(8'h24, d);
		xfer(v, d);
		desel;
		idle;
	end
endtask
// unlock sent before any select edge must be ignored
task t_boot;
	begin
		xfer(8'h21, d);
		desel;
		chk(standbyMode, 1);
		rdstat;
		chk(s, 8'h00);
	end
endtask
task t_wel;
	begin
		op1(8'h21);
		rdstat;
		chk(s, 8'h02);
		op1(8'h22);
		rdstat;
		chk(s, 8'h00);
	end
endtask
// pause mid read, toggle clock meanwhile
task t_hold;
	begin
		op1(8'h21);
		sel;
		xfer(8'h23, d);
		@(posedge clk);
		sckPin <= 1'b0;
		tick(5);
		holdPin_n <= 1'b0;
		tick(10);
		sckPin <= 1'b1;
		tick(5);
		sckPin <= 1'b0;
		tick(5);
		chk(misoOe, 0);
		holdPin_n <= 1'b1;
		tick(10);
		xfer(8'h00, s);
		desel;
		chk(s, 8'h02);
		op1(8'h22);
	end
endtask
task t_prog;
	begin
		op4(8'h26, 20'h100fe);
		xfer(8'h00, d);
		desel;
		rdbyte(20'h100fe, 8'hff);
		op1(8'h21);
		op4(8'h26, 20'h100fe);
		xfer(8'ha5, d);
		xfer(8'h3c, d);
		xfer(8'h0f, d);
		desel;
		chk(standbyMode, 0);
		rdstat;
		chk(s[0], 1);
		idle;
		chk(s, 8'h00);
		rdbyte(20'h100ff, 8'h3c);
		rdbyte(20'h10000, 8'h0f);
		op1(8'h21);
		op4(8'h26, 20'h100fe);
		xfer(8'h5a, d);
		desel;
		idle;
		rdbyte(20'h100fe, 8'h00);
	end
endtask
task t_erase;
	begin
		op4(8'h27, 20'h10000);
		desel;
		idle;
		rdbyte(20'h100fe, 8'h00);
		op1(8'h21);
		op4(8'h27, 20'h10000);
		desel;
		idle;
		rdbyte(20'h100fe, 8'hff);
	end
endtask
task t_protect;
	begin
		wrstat(8'h04);
		chk(s, 8'h04);
		op1(8'h21);
		op4(8'h26, 20'hf0000);
		xfer(8'h00, d);
		desel;
		idle;
		rdbyte(20'hf0000, 8'hff);
		op1(8'h21);
		op4(8'h26, 20'h00000);
		xfer(8'h00, d);
		desel;
		idle;
		op1(8'h21);
		op1(8'h28);
		idle;
		rdbyte(20'h00000, 8'h00);
		wrstat(8'h84);
		@(posedge clk);
		wpPin_n <= 1'b0;
		wrstat(8'h00);
		chk(s[7:2], 6'h21);
		@(posedge clk);
		wpPin_n <= 1'b1;
		wrstat(8'h00);
		op1(8'h21);
		op1(8'h28);
		idle;
		rdbyte(20'h00000, 8'hff);
	end
endtask
task t_sleep;
	begin
		op1(8'h29);
		chk(deepSleep, 1);
		op1(8'h21);
		op4(8'h2a, 20'h00000);
		xfer(8'h00, d);
		desel;
		chk(d, 8'h5a);
		chk(deepSleep, 0);
		rdstat;
		chk(s, 8'h00);
	end
endtask
// main sequence
initial begin
	tick(8);
	rst_n <= 1'b1;
	tick(5);
	t_boot;
	for (m = 0; m < 2; m = m + 1) begin
		@(posedge clk);
		cpol = m[0];
		sckPin <= m[0];
		tick(5);
		t_wel;
		t_hold;
	end
	t_prog;
	t_erase;
	t_protect;
	t_sleep;
	finalReport;
end
endmodule // tb_top
